//--- design/bdt_pkg.sv
// shared constants for the background debug command and tagging block
package bdt_pkg;
  // debug map addresses
  localparam logic [15:0] BDT_REG_BASE = 16'hFF00;
  localparam logic [15:0] BDT_REG_LAST = 16'hFF06;
  localparam logic [15:0] BDT_ROM_BASE = 16'hFF20;
  localparam logic [15:0] BDT_ROM_LAST = 16'hFFFF;
  localparam logic [15:0] BDT_ADDR_INSTR = 16'hFF00;
  localparam logic [15:0] BDT_ADDR_STATUS = 16'hFF01;
  localparam logic [15:0] BDT_ADDR_SHIFT_HI = 16'hFF02;
  localparam logic [15:0] BDT_ADDR_SHIFT_LO = 16'hFF03;
  // reset values
  localparam logic [7:0] BDT_INSTR_RESET = 8'h00;
  localparam logic [15:0] BDT_SHIFT_RESET = 16'h0000;
  // instruction register field positions
  localparam int BDT_F_HW = 7;
  localparam int BDT_F_DATA = 6;
  localparam int BDT_F_READ = 5;
  localparam int BDT_F_BACKGROUND_REQUEST_FLAG = 4;
  localparam int BDT_F_WORD = 3;
  localparam int BDT_F_MAP = 2;
  localparam int BDT_F_RESUME_CONTROL_FIELD_LO = 3;
  localparam int BDT_F_REGISTER_SELECT_FIELD_LO = 0;
  localparam logic [7:0] BDT_HW_LOW_MASK = 8'hFC;
  // status register field positions
  localparam int BDT_S_ENABLE = 7;
  localparam int BDT_S_ACTIVE = 6;
  localparam int BDT_S_TAG = 5;
  localparam int BDT_S_SDV = 4;
  localparam int BDT_S_TRACE = 3;
  // hardware background command byte
  localparam logic [7:0] BDT_OP_BACKGROUND = 8'h90;
  // resume control field codes
  localparam logic [1:0] BDT_TT_NONE = 2'h0;
  localparam logic [1:0] BDT_TT_GO = 2'h1;
  localparam logic [1:0] BDT_TT_STEP = 2'h2;
  localparam logic [1:0] BDT_TT_TAG_AND_GO_CMD = 2'h3;
  // register select field codes
  localparam logic [2:0] BDT_RS_NEXT = 3'h2;
  localparam logic [2:0] BDT_RS_PC = 3'h3;
  localparam logic [2:0] BDT_RS_D = 3'h4;
  localparam logic [2:0] BDT_RS_X = 3'h5;
  localparam logic [2:0] BDT_RS_Y = 3'h6;
  localparam logic [2:0] BDT_RS_SP = 3'h7;
  localparam logic [15:0] BDT_NEXT_STEP = 16'h0002;
  typedef enum logic [1:0] {BDT_ST_RUN, BDT_ST_ACTIVE, BDT_ST_STEP, BDT_ST_MEM} bdt_state_t;
endpackage

//--- design/bdt_debug_core.sv
// background debug command decoder, status, shifter, debug map and instruction tagging
`timescale 1ns/1ns
module bdt_debug_core
  import bdt_pkg::*;
#(
  parameter int QUEUE_DEPTH = 3
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // hardware command from the serial layer
  input wire logic hw_cmd_valid,
  input wire logic [7:0] hw_cmd_opcode,
  input wire logic hw_access,
  // firmware command from the serial layer
  input wire logic fw_cmd_valid,
  input wire logic [7:0] fw_cmd_opcode,
  input wire logic [15:0] fw_cmd_wdata,
  output logic fw_cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // cpu registers and run control
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] cpu_d,
  input wire logic [15:0] cpu_x,
  input wire logic [15:0] cpu_y,
  input wire logic [15:0] cpu_sp,
  input wire logic insn_boundary,
  output logic reg_wr,
  output logic [2:0] reg_wr_sel,
  output logic [15:0] reg_wr_data,
  output logic cpu_halt,
  // memory port for next-word transfers
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // cpu address bus into the debug map
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic map_active,
  output logic reg_sel,
  output logic rom_sel,
  // instruction queue and tag pins
  input wire logic e_clock_fall,
  input wire logic e_rise_window,
  input wire logic fetch_valid,
  input wire logic queue_advance,
  input wire logic high_tag_pin_in,
  input wire logic low_tag_pin_in,
  input wire logic low_byte_strobe,
  output logic low_tag_pin_out,
  output logic low_tag_pin_oe_n
);

  localparam int QCW = $clog2(QUEUE_DEPTH + 1);
  localparam logic [QCW-1:0] QFULL = QCW'(QUEUE_DEPTH);
  localparam logic [QCW-1:0] QONE = QCW'(1);

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  bdt_state_t state_q, state_d;
  logic [7:0] instr_q;
  logic debug_enable_q, tag_enable_q, shifter_valid_q, trace_q, bgnd_req_q;
  logic [15:0] shift_q;
  logic [7:0] bus_rdata_q;
  logic rsp_valid_q, reg_wr_q, mem_we_q;
  logic [15:0] rsp_data_q, reg_wr_data_q, mem_addr_q, mem_wdata_q;
  logic [2:0] reg_wr_sel_q;
  logic [1:0] tagq_q [QUEUE_DEPTH];
  logic [QCW-1:0] fill_q;

  // firmware field decode
  wire fw_data = fw_cmd_opcode[BDT_F_DATA];
  wire fw_read = fw_cmd_opcode[BDT_F_READ];
  wire [1:0] fw_resume_control_field = fw_cmd_opcode[BDT_F_RESUME_CONTROL_FIELD_LO +: 2];
  wire [2:0] fw_register_select_field = fw_cmd_opcode[BDT_F_REGISTER_SELECT_FIELD_LO +: 3];
  wire debug_active = (state_q == BDT_ST_ACTIVE) || (state_q == BDT_ST_MEM);
  wire waiting = (state_q == BDT_ST_ACTIVE);
  wire fw_ok = waiting && !tag_enable_q && !fw_cmd_opcode[BDT_F_HW];
  wire fw_take = fw_cmd_valid && fw_ok;
  wire fw_next = fw_take && (fw_register_select_field == BDT_RS_NEXT);
  wire fw_reg = fw_take && (fw_register_select_field >= BDT_RS_PC) && fw_data;
  wire [15:0] x_next = cpu_x + BDT_NEXT_STEP;
  wire hw_bgnd = hw_cmd_valid && (hw_cmd_opcode == BDT_OP_BACKGROUND);

  // selected cpu register for read commands
  logic [15:0] reg_value;
  always_comb
  begin
    case (fw_register_select_field)
      BDT_RS_PC: reg_value = cpu_pc;
      BDT_RS_D: reg_value = cpu_d;
      BDT_RS_X: reg_value = cpu_x;
      BDT_RS_Y: reg_value = cpu_y;
      BDT_RS_SP: reg_value = cpu_sp;
      default: reg_value = 16'h0000;
    endcase
  end

  // tag queue head and entry into active debug
  wire head_tagged = tag_enable_q && (tagq_q[0] != 2'b00) && (fill_q != '0);
  wire enter_req = (bgnd_req_q || head_tagged) && debug_enable_q;
  wire run_enter = (state_q == BDT_ST_RUN) && insn_boundary && enter_req;
  wire step_done = (state_q == BDT_ST_STEP) && insn_boundary;
  wire enter_now = run_enter || step_done;
  wire resume_go = fw_take && ((fw_resume_control_field == BDT_TT_GO) || (fw_resume_control_field == BDT_TT_TAG_AND_GO_CMD));
  wire resume_step = fw_take && (fw_resume_control_field == BDT_TT_STEP);
  wire resume_tag = fw_take && (fw_resume_control_field == BDT_TT_TAG_AND_GO_CMD);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BDT_ST_RUN:
        if (run_enter)
          state_d = BDT_ST_ACTIVE;
      BDT_ST_STEP:
        if (step_done)
          state_d = BDT_ST_ACTIVE;
      BDT_ST_ACTIVE:
        if (fw_next)
          state_d = BDT_ST_MEM;
        else if (resume_step)
          state_d = BDT_ST_STEP;
        else if (resume_go)
          state_d = BDT_ST_RUN;
      BDT_ST_MEM:
        if (mem_ack)
          state_d = BDT_ST_ACTIVE;
      default: state_d = BDT_ST_RUN;
    endcase
  end

  // debug map decode
  wire hw_map = hw_access && instr_q[BDT_F_HW] && instr_q[BDT_F_MAP];
  wire map_on = debug_active || hw_map;
  wire rom_hit = map_on && in_range(bus_addr, BDT_ROM_BASE, BDT_ROM_LAST);
  wire reg_hit = map_on && in_range(bus_addr, BDT_REG_BASE, BDT_REG_LAST);
  wire st_wr = reg_hit && bus_wr && (bus_addr == BDT_ADDR_STATUS);
  wire sh_hi_wr = reg_hit && bus_wr && (bus_addr == BDT_ADDR_SHIFT_HI);
  wire sh_lo_wr = reg_hit && bus_wr && (bus_addr == BDT_ADDR_SHIFT_LO);
  wire sh_lo_rd = reg_hit && bus_rd && (bus_addr == BDT_ADDR_SHIFT_LO);
  wire [7:0] status_val = {debug_enable_q, debug_active, tag_enable_q, shifter_valid_q,
                           trace_q, 3'h0};
  logic [7:0] reg_rd_val;
  always_comb
  begin
    case (bus_addr)
      BDT_ADDR_INSTR: reg_rd_val = instr_q;
      BDT_ADDR_STATUS: reg_rd_val = status_val;
      BDT_ADDR_SHIFT_HI: reg_rd_val = shift_q[15:8];
      BDT_ADDR_SHIFT_LO: reg_rd_val = shift_q[7:0];
      default: reg_rd_val = 8'h00;
    endcase
  end

  // shifter load sources
  wire sh_load_host = fw_take && !fw_read && fw_data;
  wire sh_load_reg = fw_reg && fw_read;
  wire sh_load_mem = (state_q == BDT_ST_MEM) && mem_ack && !mem_we_q;
  wire sh_load = sh_load_host || sh_load_reg || sh_load_mem;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= BDT_ST_RUN;
      instr_q <= BDT_INSTR_RESET;
      debug_enable_q <= 1'b0;
      tag_enable_q <= 1'b0;
      shifter_valid_q <= 1'b0;
      trace_q <= 1'b0;
      bgnd_req_q <= 1'b0;
      shift_q <= BDT_SHIFT_RESET;
      bus_rdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (hw_cmd_valid)
        instr_q <= hw_cmd_opcode & BDT_HW_LOW_MASK;
      else if (fw_take)
        instr_q <= fw_cmd_opcode;
      if (st_wr)
        debug_enable_q <= bus_wdata[BDT_S_ENABLE];
      if (hw_bgnd)
        bgnd_req_q <= debug_enable_q;
      else if (run_enter || (state_q == BDT_ST_RUN && insn_boundary))
        bgnd_req_q <= 1'b0;
      if (enter_now)
        tag_enable_q <= 1'b0;
      else if (resume_tag)
        tag_enable_q <= 1'b1;
      if (resume_step)
        trace_q <= 1'b1;
      else if (step_done)
        trace_q <= 1'b0;
      if (sh_load)
        shifter_valid_q <= 1'b1;
      else if (sh_lo_rd)
        shifter_valid_q <= 1'b0;
      if (sh_load_host)
        shift_q <= fw_cmd_wdata;
      else if (sh_load_reg)
        shift_q <= reg_value;
      else if (sh_load_mem)
        shift_q <= mem_rdata;
      else if (sh_hi_wr)
        shift_q[15:8] <= bus_wdata;
      else if (sh_lo_wr)
        shift_q[7:0] <= bus_wdata;
      if (bus_rd)
        bus_rdata_q <= reg_hit ? reg_rd_val : 8'h00;
    end
  end

  // host answers, register loads and next-word memory cycles
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
      reg_wr_q <= 1'b0;
      reg_wr_sel_q <= 3'h0;
      reg_wr_data_q <= 16'h0000;
      mem_we_q <= 1'b0;
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 16'h0000;
    end
    else
    begin
      rsp_valid_q <= sh_load_reg || sh_load_mem;
      if (sh_load_reg)
        rsp_data_q <= reg_value;
      else if (sh_load_mem)
        rsp_data_q <= mem_rdata;
      reg_wr_q <= fw_next || (fw_reg && !fw_read);
      if (fw_next)
      begin
        reg_wr_sel_q <= BDT_RS_X;
        reg_wr_data_q <= x_next;
        mem_addr_q <= x_next;
        mem_we_q <= !fw_read;
        mem_wdata_q <= fw_cmd_wdata;
      end
      else if (fw_reg && !fw_read)
      begin
        reg_wr_sel_q <= fw_register_select_field;
        reg_wr_data_q <= fw_cmd_wdata;
      end
    end
  end

  // tag capture and queue tracking
  wire fetch_now = e_clock_fall && fetch_valid;
  wire [1:0] tag_in = tag_enable_q ? {~high_tag_pin_in, ~low_tag_pin_in} : 2'b00;
  wire adv_now = queue_advance && (fill_q != '0);
  wire [QCW-1:0] fill_adv = adv_now ? fill_q - QONE : fill_q;

  always_ff @(posedge core_clk)
  begin
    if (rst || enter_now)
    begin
      fill_q <= '0;
      for (int i = 0; i < QUEUE_DEPTH; i++)
        tagq_q[i] <= 2'b00;
    end
    else
    begin
      for (int i = 0; i < QUEUE_DEPTH; i++)
        if (adv_now)
          tagq_q[i] <= (i + 1 < QUEUE_DEPTH) ? tagq_q[(i + 1) % QUEUE_DEPTH] : 2'b00;
      if (fetch_now && (fill_adv != QFULL))
        tagq_q[fill_adv[QCW-1:0] % QUEUE_DEPTH] <= tag_in;
      fill_q <= (fetch_now && (fill_adv != QFULL)) ? fill_adv + QONE : fill_adv;
    end
  end

  // outputs
  assign fw_cmd_ready = fw_ok;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign reg_wr = reg_wr_q;
  assign reg_wr_sel = reg_wr_sel_q;
  assign reg_wr_data = reg_wr_data_q;
  assign cpu_halt = debug_active;
  assign mem_req = (state_q == BDT_ST_MEM);
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign bus_rdata = bus_rdata_q;
  assign map_active = map_on;
  assign reg_sel = reg_hit;
  assign rom_sel = rom_hit;
  assign low_tag_pin_out = low_byte_strobe;
  assign low_tag_pin_oe_n = !e_rise_window;

endmodule // bdt_debug_core

//--- verif/bdt_debug_monitor.sv
// port checker for the background debug core
`timescale 1ns/1ns
module bdt_debug_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // firmware command
  input wire logic fw_cmd_valid,
  input wire logic [7:0] fw_cmd_opcode,
  input wire logic [15:0] fw_cmd_wdata,
  input wire logic fw_cmd_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  // cpu side
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] cpu_x,
  input wire logic reg_wr,
  input wire logic [2:0] reg_wr_sel,
  input wire logic [15:0] reg_wr_data,
  input wire logic cpu_halt,
  input wire logic [15:0] mem_addr,
  // debug map
  input wire logic [15:0] bus_addr,
  input wire logic map_active,
  input wire logic reg_sel,
  input wire logic rom_sel,
  // tag pins
  input wire logic e_rise_window,
  input wire logic low_byte_strobe,
  input wire logic low_tag_pin_out,
  input wire logic low_tag_pin_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic take = fw_cmd_valid && fw_cmd_ready;
  AST_ROM_MAP: assert property (rom_sel == (map_active && bus_addr >= 16'hFF20))
    else $error("rom select wrong");
  AST_REG_MAP: assert property (reg_sel == (map_active && bus_addr >= 16'hFF00 && bus_addr <= 16'hFF06))
    else $error("register select wrong");
  AST_NEXT_WORD: assert property (take && fw_cmd_opcode == 8'h62 |=> reg_wr && reg_wr_sel == 3'h5 && mem_addr == $past(cpu_x) + 16'h0002)
    else $error("next word address wrong");
  AST_CMD_A: assert property (take && fw_cmd_opcode == 8'h63 |=> rsp_valid && rsp_data == $past(cpu_pc))
    else $error("pc read wrong");
  AST_WRITE_REG: assert property (take && fw_cmd_opcode inside {[8'h43:8'h47]} |=> reg_wr && reg_wr_sel == 3'($past(fw_cmd_opcode)) && reg_wr_data == $past(fw_cmd_wdata))
    else $error("register write wrong");
  AST_GO_RESUME: assert property (take && fw_cmd_opcode == 8'h08 |=> !cpu_halt && !fw_cmd_ready)
    else $error("go did not resume");
  AST_READY_ACTIVE: assert property (fw_cmd_ready |-> cpu_halt && !fw_cmd_opcode[7])
    else $error("command ready outside active mode");
  AST_LOW_STROBE: assert property (low_tag_pin_oe_n == !e_rise_window && (!e_rise_window || low_tag_pin_out == low_byte_strobe))
    else $error("low strobe drive wrong");
  cover property (take && fw_cmd_opcode == 8'h62);
  cover property ($rose(cpu_halt));
  cover property (rom_sel);
endmodule // bdt_debug_monitor

bind bdt_debug_core bdt_debug_monitor u_mon (.*);

//--- verif/bdt_mem_model.sv
// memory partner answering next-word transfers
`timescale 1ns/1ns
module bdt_mem_model (
  // clock
  input wire logic core_clk,
  // memory port
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] slow,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  int wait_q = 0;
  initial mem_rdata = 16'h0000;
  initial mem_ack = 1'h0;
  // data shows only with ack, otherwise it keeps flipping
  always @(posedge core_clk)
  begin
    mem_ack <= 1'h0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && wait_q >= slow)
    begin
      mem_ack <= 1'h1;
      mem_rdata <= mem_addr ^ 16'h5A5A;
      wait_q <= 0;
    end
    else if (mem_req && !mem_ack)
      wait_q <= wait_q + 1;
  end
endmodule // bdt_mem_model

//--- verif/tb_top.sv
// self-checking bench of the background debug core
`timescale 1ns/1ns
module tb_top
  import bdt_pkg::*;
;
  logic core_clk = 1'h0, rst = 1'h1, hw_cmd_valid = 1'h0, hw_access = 1'h0, fw_cmd_valid = 1'h0;
  logic insn_boundary = 1'h0, bus_rd = 1'h0, bus_wr = 1'h0, e_clock_fall = 1'h0, fetch_valid = 1'h0;
  logic e_rise_window = 1'h0, queue_advance = 1'h0, low_byte_strobe = 1'h0;
  logic high_tag_pin_in = 1'h1, low_tag_pin_in = 1'h1;
  logic [7:0] hw_cmd_opcode = 8'h00, fw_cmd_opcode = 8'h00, bus_wdata = 8'h00, bus_rdata;
  logic [15:0] fw_cmd_wdata = 16'h0000, bus_addr = 16'h0000;
  logic [15:0] rsp_data, reg_wr_data, mem_addr, mem_wdata, mem_rdata;
  logic fw_cmd_ready, rsp_valid, reg_wr, cpu_halt, mem_req, mem_we, mem_ack;
  logic map_active, reg_sel, rom_sel, low_tag_pin_out, low_tag_pin_oe_n;
  logic [2:0] reg_wr_sel;
  logic [3:0] slow = 4'h0;
  logic [15:0] regs [5] = '{default: 16'h0000};
  wire logic [15:0] cpu_pc = regs[0];
  wire logic [15:0] cpu_d = regs[1];
  wire logic [15:0] cpu_x = regs[2];
  wire logic [15:0] cpu_y = regs[3];
  wire logic [15:0] cpu_sp = regs[4];
  // low tag pin only matters while it is driven around the rising e edge
  wire logic [15:0] lt_seen = {14'h0000, low_tag_pin_oe_n, low_tag_pin_out & e_rise_window};
  wire logic [15:0] lt_exp = {14'h0000, !e_rise_window, low_byte_strobe & e_rise_window};
  logic [31:0] seed = 32'h7CFD, strb_seed = 32'h7CFD;
  int num_errors = 0, compares = 0, cycles = 0, n, exp_st = 0;
  bdt_debug_core #(.QUEUE_DEPTH(3)) dut (.*);
  bdt_mem_model u_mem (.*);
  initial forever #10 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic print_verdict();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(int k = 1);
    repeat (k) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic hw(logic [7:0] op);
    tick();
    hw_cmd_valid = 1'h1;
    hw_cmd_opcode = op;
    tick();
    hw_cmd_valid = 1'h0;
    tick(150);
  endtask
  task automatic fw(logic [7:0] op, logic [15:0] wd);
    tick();
    fw_cmd_opcode = op;
    fw_cmd_wdata = wd;
    fw_cmd_valid = 1'h1;
    tick();
    fw_cmd_valid = 1'h0;
  endtask
  // byte access through the hardware command path, in the map when op sets the hw and map bits or while debug is active
  task automatic bus(logic [7:0] op, logic wr, logic [7:0] d, logic [15:0] a = BDT_ADDR_STATUS);
    hw(op);
    hw_access = 1'h1;
    bus_addr = a;
    bus_wr = wr;
    bus_rd = !wr;
    bus_wdata = d;
    tick();
    bus_rd = 1'h0;
    bus_wr = 1'h0;
    hw_access = 1'h0;
  endtask
  task automatic status();
    bus(8'hE4, 1'h0, 8'h00);
    chk("status", {8'h00, bus_rdata}, 16'(exp_st[7:0]));
  endtask
  task automatic bnd();
    insn_boundary = 1'h1;
    tick();
    insn_boundary = 1'h0;
    tick();
  endtask
  always @(posedge core_clk)
  begin
    #2;
    strb_seed = lfsr(strb_seed);
    e_rise_window = strb_seed[0];
    low_byte_strobe = strb_seed[1];
    #1;
    chk("low_tag", lt_seen, lt_exp);
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    tick(5);
    rst = 1'h0;
    status();
    hw(8'h90);
    bnd();
    chk("halt", 16'(cpu_halt), 16'h0000);
    bus(8'hC4, 1'h1, 8'hFF);
    exp_st = 8'h80;
    status();
    hw(8'h90);
    bnd();
    exp_st = 8'hC0;
    chk("halt", 16'(cpu_halt), 16'h0001);
    status();
    bus_addr = BDT_ROM_BASE;
    tick();
    chk("map_rom", {13'h0000, map_active, reg_sel, rom_sel}, 16'h0005);
    bus_addr = BDT_REG_LAST;
    tick();
    chk("map_reg", {13'h0000, map_active, reg_sel, rom_sel}, 16'h0006);
    bus_addr = BDT_REG_LAST + 16'h0001;
    tick();
    chk("map_gap", {13'h0000, map_active, reg_sel, rom_sel}, 16'h0004);
    for (int i = 0; i < 5; i++)
    begin
      seed = lfsr(seed);
      regs[i] = seed[15:0];
    end
    for (int i = 0; i < 5; i++)
    begin
      fw(8'h63 + 8'(i), 16'h0000);
      chk("rsp", {rsp_valid, 15'h0000} ^ rsp_data, {1'h1, 15'h0000} ^ regs[i]);
      seed = lfsr(seed);
      fw(8'h43 + 8'(i), seed[15:0]);
      chk("reg_wr", {reg_wr, 12'h000, reg_wr_sel}, {1'h1, 12'h000, 3'(i + 3)});
      chk("reg_wr_data", reg_wr_data, seed[15:0]);
    end
    for (int i = 0; i < 2; i++)
    begin
      slow = 4'(i * 3);
      fw(8'h62, 16'h0000);
      chk("next_addr", mem_addr, regs[2] + 16'h0002);
      chk("x_inc", reg_wr_data, regs[2] + 16'h0002);
      chk("mem_req", 16'(mem_req), 16'h0001);
      n = 0;
      while (rsp_valid !== 1'h1 && n < 20)
      begin
        tick();
        n++;
      end
      chk("next_data", rsp_data, (regs[2] + 16'h0002) ^ 16'h5A5A);
      regs[2] = regs[2] + 16'h0002;
    end
    fw(8'h42, 16'hC3A5);
    chk("wnext", {mem_we, 15'h0000} ^ mem_wdata, 16'h43A5);
    chk("wnext_addr", mem_addr, regs[2] + 16'h0002);
    tick(3);
    bus(8'hE4, 1'h0, 8'h00, BDT_ADDR_SHIFT_LO);
    chk("shift_lo", {8'h00, bus_rdata}, 16'h00A5);
    bus(8'hE4, 1'h0, 8'h00, BDT_ADDR_INSTR);
    chk("instr", {8'h00, bus_rdata}, 16'h00E4);
    fw(8'h08, 16'h0000);
    chk("go", {cpu_halt, 14'h0000, fw_cmd_ready}, 16'h0000);
    bus_addr = BDT_ROM_BASE;
    tick();
    chk("map_off", {13'h0000, map_active, reg_sel, rom_sel}, 16'h0000);
    bus(8'hE0, 1'h0, 8'h00);
    chk("out_map", {8'h00, bus_rdata}, 16'h0000);
    exp_st = 8'h80;
    status();
    hw(8'h90);
    bnd();
    fw(8'h10, 16'h0000);
    exp_st = 8'h88;
    status();
    bnd();
    exp_st = 8'hC0;
    status();
    fw(8'h18, 16'h0000);
    exp_st = 8'hA0;
    status();
    high_tag_pin_in = 1'h0;
    fetch_valid = 1'h1;
    e_clock_fall = 1'h1;
    tick();
    high_tag_pin_in = 1'h1;
    fetch_valid = 1'h0;
    e_clock_fall = 1'h0;
    bnd();
    exp_st = 8'hC0;
    chk("tag_halt", 16'(cpu_halt), 16'h0001);
    status();
    print_verdict();
  end
endmodule // tb_top
